/* File: dv/gyro_fault_monitor_and_rate_format_test.sv */
// Purpose: bench for the fault monitor and rate framing
// Assumes: inputs change at falling mclk
// Notes:   inject time shortened to 50 cycles
`timescale 1ns/1ps
`include "fault_mon_map.svh"
module gyro_fault_monitor_and_rate_format_test;
  import fault_mon_pkg::*;
  localparam int INJ = 50;
  localparam logic [17:0] RIN [4] = '{18'h00050, 18'h10000, 18'h20000, 18'h3FFEC};
  localparam logic [15:0] REX [4] = '{16'h0050, 16'h7FFF, 16'h8000, 16'hFFEC};
  localparam logic [15:0] SIN [5] = '{16'h0200, 16'h0201, 16'hFDFF, 16'h0741, 16'hF8BF};
  localparam logic        SFL [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  localparam logic [1:0]  SKD [5] = '{2'b01, 2'b01, 2'b01, 2'b00, 2'b00};
  logic        mclk_in = 1'b0;
  logic        rst_n_in, ov, un, rd, rw, inj, sclk, cs_n, miso, load, act;
  logic [15:0] st, mem, rwd;
  logic [17:0] raw;
  logic [31:0] w;
  faults_s     f;
  kind_e       kind;
  int          errors, n_compared;
  always #50 mclk_in = ~mclk_in;
  spi_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .miso_in(miso));
  fault_mon #(.INJECT_CYCLES(INJ), .FILT_DEPTH(8)) dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_over_in(ov), .reg_under_in(un),
    .selftest_in(st), .rate_raw_in(raw), .check_mem_in(mem), .flag_read_in(rd),
    .rw_cmd_in(rw), .rw_data_in(rwd), .fault_inject_bit_in(inj),
    .link_sclk_in(sclk), .cs_n_in(cs_n), .miso_out(miso), .faults_out(f),
    .response_kind_field_out(kind), .check_load_out(load), .inject_active_out(act));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic clr();
    rd = 1'b1;
    cyc(4);
    rd = 1'b0;
    cyc(4);
  endtask
  task automatic end_of_test();
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    {rst_n_in, ov, un, rd, rw, inj} = 6'h00;
    st = 16'h0000;
    mem = `ROM_CONST;
    rwd = 16'h0000;
    raw = 18'h00000;
    errors = 0;
    n_compared = 0;
    cyc(16);
    rst_n_in = 1'b1;
    cyc(4);
    chk(f, 5'h00);
    chk({load, act, kind}, 4'h9);
    for (int i = 0; i < 4; i++) begin
      raw = RIN[i];
      host.frame(w);
      raw = 18'h00000;
      host.frame(w);
      chk(w[25:10], REX[i]);
      chk({w[31:26], w[9:0]}, 16'h0400);
    end
    rw = 1'b1;
    rwd = 16'h1234;
    host.frame(w);
    rw = 1'b0;
    host.frame(w);
    chk(w[27:10], 18'h31234);
    for (int k = 0; k < 2; k++) begin
      {ov, un} = k ? 2'b01 : 2'b10;
      cyc(3);
      {ov, un} = 2'b00;
      cyc(20);
      chk(f, 5'h00);
      {ov, un} = k ? 2'b01 : 2'b10;
      cyc(20);
      chk(f[4:2], k ? 3'h5 : 3'h6);
      clr();
      chk(f.supply_fault_flag, 1'b1);
      {ov, un} = 2'b00;
      cyc(20);
      chk(f.supply_fault_flag, 1'b1);
      clr();
      chk(f, 5'h00);
    end
    for (int i = 0; i < 5; i++) begin
      st = SIN[i];
      cyc(20);
      chk(f.selftest_fault_flag, SFL[i]);
      chk(kind, SKD[i]);
      st = 16'h0000;
      cyc(20);
      clr();
    end
    mem = ~`ROM_CONST;
    cyc(15);
    chk(f.init_check_flag, 1'b1);
    mem = `ROM_CONST;
    cyc(15);
    clr();
    chk(f, 5'h00);
    inj = 1'b1;
    cyc(INJ + 10);
    chk(f, 5'h1F);
    chk(kind, KIND_SELFTEST);
    host.frame(w);
    host.frame(w);
    chk(w[27:26], KIND_SELFTEST);
    chk(w[9:5], 5'h1F);
    inj = 1'b0;
    cyc(10);
    chk(act, 1'b1);
    chk(kind, KIND_INVALID);
    cyc(INJ - 20);
    chk(act, 1'b1);
    cyc(30);
    chk(act, 1'b0);
    chk(kind, KIND_INVALID);
    clr();
    chk({f, kind}, 7'h01);
    end_of_test();
  end
  initial begin
    #5000000;
    errors++;
    end_of_test();
  end
endmodule

/* File: dv/spi_host_model.sv */
// Purpose: host end of the serial link
// Assumes: link clock idles low and stands still outside frames
// Notes:   48 ns link period, data sampled late in the low phase
`timescale 1ns/1ps
module spi_host_model (
  output logic     sclk_out,
  output logic     cs_n_out,
  input  wire logic miso_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
  end
  task automatic frame(output logic [31:0] word);
    cs_n_out = 1'b0;
    #1107;
    for (int i = 31; i >= 0; i--) begin
      sclk_out = 1'b1;
      #24;
      sclk_out = 1'b0;
      #20;
      word[i] = miso_in;
      #4;
    end
    #24;
    cs_n_out = 1'b1;
    #1133;
  endtask
endmodule

/* File: hdl/fault_mon.sv */
// Purpose: fault supervision, fault injection and rate word framing
// Assumes: host clocks the frame on link_sclk_in, cs low frames a transfer
// Notes:   flags latched in core domain, snapshot crosses by synchronised toggle
// How it works
// - ROM constant compared every microsecond
// - Check register takes ROM constant after reset, then check memory every cycle
// - Supply fault is high or low
// - Regulator levels filtered before flagging
// - Self-test beyond 512 sets flag
// - Beyond 1856 forces invalid kind
// - Inject forces every fault
// - Injected faults appear within 50 ms
// - Kind is self-test while inject set
// - Faults decay 50 ms after clear
// - Data latched at select, sent next
// - Other commands answered next exchange
// - Data after inject is error until self-test flag clears
// - 16-bit rate in 32-bit frame, MSB first
// - Twos complement, 80 LSB per dps
// - Rate saturates at extremes
// - Kind codes 00 01 10 11
// - Flags held until read, reassert
`timescale 1ns/1ps
`include "fault_mon_map.svh"
module fault_mon #(
  parameter int INJECT_CYCLES = `INJECT_CYCLES,
  parameter int FILT_DEPTH    = `FILT_DEPTH
) (
  input  wire logic                    mclk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    reg_over_in,
  input  wire logic                    reg_under_in,
  input  wire logic [15:0]             selftest_in,
  input  wire logic [17:0]             rate_raw_in,
  input  wire logic [15:0]             check_mem_in,
  input  wire logic                    flag_read_in,
  input  wire logic                    rw_cmd_in,
  input  wire logic [15:0]             rw_data_in,
  input  wire logic                    fault_inject_bit_in,
  input  wire logic                    link_sclk_in,
  input  wire logic                    cs_n_in,
  output logic                         miso_out,
  output fault_mon_pkg::faults_s       faults_out,
  output fault_mon_pkg::kind_e         response_kind_field_out,
  output logic                         check_load_out,
  output logic                         inject_active_out
);
  import fault_mon_pkg::*;

  initial begin
    if (FILT_DEPTH < 2 || FILT_DEPTH > 32 || INJECT_CYCLES < 1) begin
      $error("fault_mon: unsupported parameters");
    end
  end

  // Synchronisers for pins
  logic [1:0] ov_s_q, uv_s_q, inj_s_q, rd_s_q, cs_s_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ov_s_q  <= 2'h0;
      uv_s_q  <= 2'h0;
      inj_s_q <= 2'h0;
      rd_s_q  <= 2'h0;
      cs_s_q  <= 2'h3;
    end else begin
      ov_s_q  <= {ov_s_q[0], reg_over_in};
      uv_s_q  <= {uv_s_q[0], reg_under_in};
      inj_s_q <= {inj_s_q[0], fault_inject_bit_in};
      rd_s_q  <= {rd_s_q[0], flag_read_in};
      cs_s_q  <= {cs_s_q[0], cs_n_in};
    end
  end

  logic rd_q;
  logic rd_pulse;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) rd_q <= 1'b0;
    else rd_q <= rd_s_q[1];
  end
  assign rd_pulse = rd_s_q[1] & ~rd_q;

  // Injection sequencer
  inj_e inj_q;
  logic [31:0] inj_cnt_q;
  logic inj_forcing;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      inj_q     <= INJ_IDLE;
      inj_cnt_q <= 32'h0;
    end else begin
      unique case (inj_q)
        INJ_IDLE: begin
          inj_cnt_q <= 32'h0;
          if (inj_s_q[1]) inj_q <= INJ_ON;
        end
        INJ_ON: begin
          if (!inj_s_q[1]) begin
            inj_q     <= INJ_DECAY;
            inj_cnt_q <= 32'h0;
          end
        end
        INJ_DECAY: begin
          if (inj_s_q[1]) inj_q <= INJ_ON;
          else if (inj_cnt_q >= 32'(INJECT_CYCLES - 1)) inj_q <= INJ_IDLE;
          else inj_cnt_q <= inj_cnt_q + 32'h1;
        end
        default: inj_q <= INJ_IDLE;
      endcase
    end
  end
  assign inj_forcing = (inj_q != INJ_IDLE);

  logic [15:0] chk_reg_q;
  logic [7:0]  chk_cnt_q;
  logic        chk_loaded_q;
  logic        chk_err;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chk_reg_q    <= 16'h0;
      chk_loaded_q <= 1'b0;
      chk_cnt_q    <= 8'h0;
    end else begin
      if (!chk_loaded_q) begin
        chk_reg_q    <= `ROM_CONST;
        chk_loaded_q <= 1'b1;
      end else begin
        chk_reg_q <= check_mem_in;
      end
      if (chk_cnt_q == 8'(`CHECK_CYCLES - 1)) chk_cnt_q <= 8'h0;
      else chk_cnt_q <= chk_cnt_q + 8'h1;
    end
  end
  assign chk_err = chk_loaded_q && (chk_cnt_q == 8'h0) && (chk_reg_q != `ROM_CONST);

  logic [5:0] ov_f_q, uv_f_q;
  logic ov_hit, uv_hit;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ov_f_q <= 6'h0;
      uv_f_q <= 6'h0;
    end else begin
      if (ov_s_q[1]) ov_f_q <= (ov_f_q == 6'(FILT_DEPTH)) ? ov_f_q : ov_f_q + 6'h1;
      else ov_f_q <= 6'h0;
      if (uv_s_q[1]) uv_f_q <= (uv_f_q == 6'(FILT_DEPTH)) ? uv_f_q : uv_f_q + 6'h1;
      else uv_f_q <= 6'h0;
    end
  end
  assign ov_hit = (ov_f_q == 6'(FILT_DEPTH)) | inj_forcing;
  assign uv_hit = (uv_f_q == 6'(FILT_DEPTH)) | inj_forcing;

  localparam logic [15:0] ST_NOM = `ST_NOMINAL;
  logic signed [16:0] st_dev;
  logic [16:0] st_abs;
  logic st_warn, st_fail;
  assign st_dev  = $signed({selftest_in[15], selftest_in})
                 - $signed({ST_NOM[15], ST_NOM});
  assign st_abs  = st_dev[16] ? 17'(-st_dev) : 17'(st_dev);
  assign st_warn = (st_abs > `ST_WARN_LSB) | inj_forcing;
  assign st_fail = (st_abs > `ST_FAIL_LSB) | inj_forcing;

  // sticky flags, set wins over read
  faults_s flags_q;
  faults_s hits;
  assign hits.regulator_high_flag = ov_hit;
  assign hits.regulator_low_flag  = uv_hit;
  assign hits.supply_fault_flag   = ov_hit | uv_hit;
  assign hits.selftest_fault_flag = st_warn;
  assign hits.init_check_flag     = chk_err | inj_forcing;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) flags_q <= '0;
    else if (rd_pulse) flags_q <= hits;
    else flags_q <= flags_q | hits;
  end

  // error data until self-test flag read after inject
  logic post_inj_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) post_inj_q <= 1'b0;
    else if (inj_q == INJ_ON && !inj_s_q[1]) post_inj_q <= 1'b1;
    else if (!inj_forcing && !flags_q.selftest_fault_flag) post_inj_q <= 1'b0;
  end

  kind_e kind_d;
  always_comb begin
    if (inj_s_q[1]) kind_d = KIND_SELFTEST;
    else if (st_fail || (post_inj_q && flags_q.selftest_fault_flag)) kind_d = KIND_INVALID;
    else if (rw_cmd_in) kind_d = KIND_RW;
    else kind_d = KIND_VALID;
  end

  logic [15:0] rate_sat;
  always_comb begin
    if ($signed(rate_raw_in) > $signed(18'sh07FFF)) rate_sat = `RATE_POS_SAT;
    else if ($signed(rate_raw_in) < -$signed(18'sh08000)) rate_sat = `RATE_NEG_SAT;
    else rate_sat = rate_raw_in[15:0];
  end

  // snapshot at select, handed to the link
  logic [31:0] snap_q;
  logic        snap_tog_q;
  logic        cs_prev_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      snap_q     <= 32'h0;
      snap_tog_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      cs_prev_q <= cs_s_q[1];
      if (cs_prev_q && !cs_s_q[1]) begin
        snap_q     <= {4'h0, kind_d, rw_cmd_in ? rw_data_in : rate_sat,
                       flags_q, 5'h0};
        snap_tog_q <= ~snap_tog_q;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      faults_out              <= '0;
      response_kind_field_out <= KIND_VALID;
      check_load_out          <= 1'b0;
      inject_active_out       <= 1'b0;
    end else begin
      faults_out              <= flags_q;
      response_kind_field_out <= kind_d;
      check_load_out          <= chk_loaded_q;
      inject_active_out       <= inj_forcing;
    end
  end

  logic [1:0]  tog_s_q;
  logic        tog_seen_q;
  logic [31:0] frame_q, shift_q;
  logic [4:0]  bit_q;
  always_ff @(posedge link_sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tog_s_q    <= 2'h0;
      tog_seen_q <= 1'b0;
      frame_q    <= 32'h0;
    end else begin
      tog_s_q <= {tog_s_q[0], snap_tog_q};
      if (tog_s_q[1] != tog_seen_q) begin
        tog_seen_q <= tog_s_q[1];
        frame_q    <= snap_q;
      end
    end
  end
  always_ff @(negedge link_sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_q  <= 32'h0;
      bit_q    <= 5'h0;
      miso_out <= 1'b0;
    end else if (cs_n_in) begin
      bit_q   <= 5'h0;
      shift_q <= frame_q;
    end else begin
      miso_out <= (bit_q == 5'h0) ? frame_q[31] : shift_q[31];
      shift_q  <= ((bit_q == 5'h0) ? frame_q : shift_q) << 1;
      bit_q    <= bit_q + 5'h1;
    end
  end

  // Assertions
  supply_or_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (ov_hit || uv_hit) |=> flags_q.supply_fault_flag) else $error("supply flag missed");
  kind_inject_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    inj_s_q[1] |-> kind_d == KIND_SELFTEST) else $error("kind not selftest");
  kind_fail_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (!inj_s_q[1] && st_abs > 17'h00740) |-> kind_d == KIND_INVALID)
    else $error("kind not invalid");
  st_warn_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (st_abs > 17'h00200) |=> flags_q.selftest_fault_flag) else $error("selftest flag missed");
  sat_pos_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ($signed(rate_raw_in) > 32767) |-> rate_sat == 16'h7FFF) else $error("no saturation");
  inject_all_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    inj_forcing |=> (flags_q == 5'h1F)) else $error("inject incomplete");
  sticky_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (flags_q.init_check_flag && !rd_pulse) |=> flags_q.init_check_flag) else $error("flag lost");
  filter_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (!ov_s_q[1] && !inj_forcing && !inj_s_q[1]) |=> !ov_hit) else $error("glitch passed");
  post_inject_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (post_inj_q && flags_q.selftest_fault_flag && !inj_s_q[1]) |-> kind_d == KIND_INVALID)
    else $error("kind not error after inject");
  decay_bound_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (inj_q == INJ_DECAY) |-> inj_cnt_q < 32'(INJECT_CYCLES)) else $error("decay overran");
  inject_time_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (inj_s_q[1] && inj_q == INJ_IDLE) |=> ##1 (flags_q == 5'h1F)) else $error("inject late");
  check_flag_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    chk_err |=> flags_q.init_check_flag) else $error("check flag missed");
endmodule

/* File: hdl/fault_mon_map.svh */
// Purpose: constants for the fault monitor and rate formatter
// Assumes: 10 MHz core clock
// Notes:   times kept in their own unit, cycle counts derived
`ifndef FAULT_MON_MAP_SVH
`define FAULT_MON_MAP_SVH
`define CLK_MHZ           10
`define CHECK_PERIOD_US   1
`define CHECK_CYCLES      (`CHECK_PERIOD_US * `CLK_MHZ)
`define INJECT_TIME_MS    50
`define INJECT_CYCLES     (`INJECT_TIME_MS * 1000 * `CLK_MHZ)
`define ROM_CONST         16'hA5C3
`define ST_WARN_LSB       17'h00200
`define ST_FAIL_LSB       17'h00740
`define ST_NOMINAL        16'h0000
`define RATE_POS_SAT      16'h7FFF
`define RATE_NEG_SAT      16'h8000
`define FILT_DEPTH        8
`define FRAME_BITS        32
`endif

/* File: hdl/fault_mon_pkg.sv */
// Purpose: types for the fault monitor and rate formatter
// Assumes: nothing
// Notes:   encodings of the response kind
package fault_mon_pkg;
  typedef enum logic [1:0] {
    KIND_INVALID  = 2'b00,
    KIND_VALID    = 2'b01,
    KIND_SELFTEST = 2'b10,
    KIND_RW       = 2'b11
  } kind_e;
  typedef struct packed {
    logic supply_fault_flag;
    logic regulator_high_flag;
    logic regulator_low_flag;
    logic selftest_fault_flag;
    logic init_check_flag;
  } faults_s;
  typedef enum logic [1:0] {
    INJ_IDLE  = 2'b00,
    INJ_ON    = 2'b01,
    INJ_DECAY = 2'b10
  } inj_e;
endpackage
